// ### rtl/dmz_pkg.sv
// shared constants, types and latency decode for mode register zero
`default_nettype none
package dmz_pkg;

  localparam int unsigned MR_WIDTH      = 22;
  localparam logic [21:0] MR_RESET      = 22'h000000;
  localparam logic [2:0]  MR_SELECT     = 3'h0;
  localparam int unsigned DLL_RST_BIT   = 8;
  localparam int unsigned TEST_BIT      = 7;
  localparam int unsigned ORDER_BIT     = 3;
  localparam int unsigned SIZE_LSB      = 0;
  localparam int unsigned CL_BIT4       = 12;
  localparam int unsigned CL_BIT3_MSB   = 6;
  localparam int unsigned CL_BIT3_LSB   = 4;
  localparam int unsigned CL_BIT0       = 2;
  localparam int unsigned CHOP_SEL_BIT  = 12;

  localparam logic [1:0]  SIZE_FIXED8   = 2'h0;
  localparam logic [1:0]  SIZE_PER_CMD  = 2'h1;
  localparam logic [1:0]  SIZE_FIXED4   = 2'h2;

  localparam logic [2:0]  LAST_BEAT     = 3'h7;
  localparam logic [2:0]  CHOP_LAST     = 3'h3;
  localparam logic [2:0]  WR_START_FULL = 3'h7;
  localparam logic [2:0]  WR_START_CHOP = 3'h5;
  localparam logic [6:0]  RL_LEAD       = 7'h03;

  typedef struct packed {
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
  } dmz_cmd_s;

  typedef struct packed {
    logic [2:0] col;
    logic       active;
    logic       write;
    logic       last;
  } dmz_beat_s;

  // zero marks a code with no defined latency
  function automatic logic [5:0] dmz_cl_decode(input logic [4:0] code);
    logic [5:0] clk;
    clk = 6'h00;
    case (code)
      5'h00, 5'h01, 5'h02, 5'h03,
      5'h04, 5'h05, 5'h06, 5'h07: clk = 6'h09 + {3'h0, code[2:0]};
      5'h08: clk = 6'h12;
      5'h09: clk = 6'h14;
      5'h0a: clk = 6'h16;
      5'h0b: clk = 6'h18;
      5'h0c: clk = 6'h17;
      5'h0d: clk = 6'h11;
      5'h0e: clk = 6'h13;
      5'h0f: clk = 6'h15;
      5'h10: clk = 6'h19;
      5'h11: clk = 6'h1a;
      5'h13: clk = 6'h1c;
      5'h14: clk = 6'h1d;
      5'h15: clk = 6'h1e;
      5'h16: clk = 6'h1f;
      5'h17: clk = 6'h20;
      default: clk = 6'h00;
    endcase
    return clk;
  endfunction : dmz_cl_decode

endpackage : dmz_pkg
`default_nettype wire

// ### rtl/dmz_col_order.sv
// column index of one beat within a burst
`timescale 1ns/10ps
`default_nettype none
module dmz_col_order (
  input  wire logic [2:0] start_i,
  input  wire logic [2:0] beat_i,
  input  wire logic       interleave_i,
  input  wire logic       write_i,
  output logic      [2:0] col_o
);
  import dmz_pkg::*;

  logic [1:0] low_sum;

  assign low_sum = start_i[1:0] + beat_i[1:0];

  always_comb begin
    if (interleave_i && !write_i) begin
      col_o = start_i ^ beat_i;
    end else begin
      // writes arrive with low start bits already cleared
      col_o = {start_i[2] ^ beat_i[2], low_sum};
    end
  end

endmodule : dmz_col_order
`default_nettype wire

// ### rtl/dmz_beat_buf.sv
// two-entry beat buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dmz_beat_buf (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               clk_en_i,
  input  wire logic               in_valid_i,
  output logic                    in_ready_o,
  input  wire dmz_pkg::dmz_beat_s in_beat_i,
  output logic                    out_valid_o,
  input  wire logic               out_ready_i,
  output dmz_pkg::dmz_beat_s      out_beat_o
);
  import dmz_pkg::*;

  typedef struct packed {
    dmz_beat_s [1:0] mem;
    logic            wr_ptr;
    logic            rd_ptr;
    logic [1:0]      count;
  } dmz_buf_s;

  dmz_buf_s cur;
  dmz_buf_s next_cur;
  logic     push;
  logic     pop;

  assign in_ready_o  = clk_en_i && (cur.count != 2'h2);
  assign out_valid_o = cur.count != 2'h0;
  assign out_beat_o  = cur.mem[cur.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = clk_en_i && out_valid_o && out_ready_i;

  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.mem[cur.wr_ptr] = in_beat_i;
      next_cur.wr_ptr          = ~cur.wr_ptr;
    end
    if (pop) begin
      next_cur.rd_ptr = ~cur.rd_ptr;
    end
    case ({push, pop})
      2'b10:   next_cur.count = cur.count + 2'h1;
      2'b01:   next_cur.count = cur.count - 2'h1;
      default: next_cur.count = cur.count;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
    end else if (clk_en_i) begin
      cur <= next_cur;
    end
  end

endmodule : dmz_beat_buf
`default_nettype wire

// ### rtl/dmz_mode_zero.sv
// mode register zero, latency derivation and burst column sequencing
`timescale 1ns/10ps
`default_nettype none
module dmz_mode_zero (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               clk_en_i,
  input  wire logic               cmd_valid_i,
  input  wire dmz_pkg::dmz_cmd_s  cmd_i,
  input  wire logic [4:0]         added_command_latency_i,
  output logic                    dll_reset_o,
  output logic                    factory_test_o,
  output logic [5:0]              column_access_latency_o,
  output logic [6:0]              total_read_latency_o,
  output logic                    burst_order_type_o,
  output logic [1:0]              burst_size_field_o,
  output logic                    latency_illegal_o,
  output logic                    size_illegal_o,
  output logic                    burst_busy_o,
  output logic                    cmd_refused_o,
  output logic                    internal_write_start_o,
  output logic                    beat_valid_o,
  input  wire logic               beat_ready_i,
  output dmz_pkg::dmz_beat_s      beat_o
);
  import dmz_pkg::*;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_BEATS
  } dmz_phase_e;

  typedef struct packed {
    logic [21:0] mode_register_zero;
    logic [5:0]  cl;
    logic [6:0]  rl;
    logic        lat_bad;
    logic        dll_pulse;
    logic        refused;
    logic        wr_start;
    dmz_phase_e  phase;
    logic [6:0]  wait_cnt;
    logic [2:0]  beat;
    logic [2:0]  start;
    logic        write;
    logic        chop;
    logic        interleave;
    logic        fixed4;
  } dmz_core_s;

  dmz_core_s  cur;
  dmz_core_s  next_cur;

  logic       is_col_cmd;
  logic       is_mode_set;
  logic       is_read;
  logic       is_write;
  logic [4:0] cl_code;
  logic [5:0] cl_new;
  logic [1:0] size_now;
  logic       chop_now;
  logic [2:0] start_now;
  logic [6:0] rl_sum;
  logic [2:0] beat_col;
  logic       push_valid;
  logic       push_ready;
  dmz_beat_s  push_beat;

  // pins come from the controller on this same clock
  // select is bg[0] and ba; bg[1] is a reserved bit stored as written
  assign is_mode_set = cmd_valid_i && !cmd_i.ras_n && !cmd_i.cas_n &&
                       !cmd_i.we_n &&
                       ({cmd_i.bg[0], cmd_i.ba} == MR_SELECT);
  assign is_col_cmd  = cmd_valid_i && cmd_i.ras_n && !cmd_i.cas_n;
  assign is_read     = is_col_cmd && cmd_i.we_n;
  assign is_write    = is_col_cmd && !cmd_i.we_n;

  // five-bit code spread over address bits 12, 6:4 and 2
  assign cl_code = {cmd_i.addr[CL_BIT4],
                    cmd_i.addr[CL_BIT3_MSB:CL_BIT3_LSB],
                    cmd_i.addr[CL_BIT0]};
  assign cl_new  = dmz_cl_decode(cl_code);

  assign rl_sum = {2'h0, added_command_latency_i} +
                  {1'h0, cur.cl};

  // column commands always use the stored setting, never a pending one
  assign size_now =
    cur.mode_register_zero[SIZE_LSB+1:SIZE_LSB];

  always_comb begin
    case (size_now)
      SIZE_FIXED8:  chop_now = 1'b0;
      SIZE_PER_CMD: chop_now = !cmd_i.addr[CHOP_SEL_BIT];
      SIZE_FIXED4:  chop_now = 1'b1;
      // reserved pattern falls back to a full burst
      default:      chop_now = 1'b0;
    endcase
  end

  always_comb begin
    if (!is_write) begin
      start_now = cmd_i.addr[2:0];
    end else if (chop_now) begin
      start_now = {cmd_i.addr[2], 2'h0};
    end else begin
      start_now = 3'h0;
    end
  end

  dmz_col_order u_order (
    .start_i      (cur.start),
    .beat_i       (cur.beat),
    .interleave_i (cur.interleave),
    .write_i      (cur.write),
    .col_o        (beat_col)
  );

  always_comb begin
    push_beat        = '0;
    push_beat.col    = beat_col;
    push_beat.write  = cur.write;
    push_beat.last   = cur.beat == LAST_BEAT;
    // chopped tail: read drivers off, write data discarded
    push_beat.active = !(cur.chop && (cur.beat > CHOP_LAST));
  end

  always_comb begin
    next_cur           = cur;
    next_cur.dll_pulse = 1'b0;
    next_cur.refused   = 1'b0;
    next_cur.wr_start  = 1'b0;
    push_valid         = 1'b0;
    next_cur.rl        = rl_sum;

    if (is_mode_set) begin
      next_cur.mode_register_zero = {cmd_i.bg, cmd_i.ba, cmd_i.addr[17],
                                     3'h0, cmd_i.addr[13:0]};
      // loop reset is an action, the stored bit returns to zero
      next_cur.mode_register_zero[DLL_RST_BIT] = 1'b0;
      next_cur.dll_pulse = cmd_i.addr[DLL_RST_BIT];
      next_cur.cl        = cl_new;
      next_cur.lat_bad   = cl_new == 6'h00;
    end

    case (cur.phase)
      PH_IDLE: begin
        if (is_read || is_write) begin
          // settings frozen for the whole burst
          next_cur.start      = start_now;
          next_cur.write      = is_write;
          next_cur.chop       = chop_now;
          next_cur.interleave =
            cur.mode_register_zero[ORDER_BIT];
          next_cur.fixed4     = size_now == SIZE_FIXED4;
          next_cur.beat       = 3'h0;
          if (is_write) begin
            next_cur.phase = PH_BEATS;
          end else if (cur.rl > RL_LEAD) begin
            // buffer and phase changes use the lead cycles
            next_cur.wait_cnt = cur.rl - RL_LEAD;
            next_cur.phase    = PH_WAIT;
          end else begin
            next_cur.phase = PH_BEATS;
          end
        end
      end
      PH_WAIT: begin
        if (is_read || is_write) begin
          next_cur.refused = 1'b1;
        end
        if (cur.wait_cnt == 7'h00) begin
          next_cur.phase = PH_BEATS;
        end else begin
          next_cur.wait_cnt = cur.wait_cnt - 7'h01;
        end
      end
      PH_BEATS: begin
        if (is_read || is_write) begin
          next_cur.refused = 1'b1;
        end
        push_valid = 1'b1;
        if (push_ready) begin
          if (cur.write && (cur.beat ==
              (cur.fixed4 ? WR_START_CHOP : WR_START_FULL))) begin
            next_cur.wr_start = 1'b1;
          end
          if (cur.beat == LAST_BEAT) begin
            next_cur.phase = PH_IDLE;
          end else begin
            next_cur.beat = cur.beat + 3'h1;
          end
        end
      end
      default: begin
        next_cur.phase = PH_IDLE;
      end
    endcase
  end

  // a stalled receiver holds the sequencer; read latency then slips
  dmz_beat_buf u_buf (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_beat_i   (push_beat),
    .out_valid_o (beat_valid_o),
    .out_ready_i (beat_ready_i),
    .out_beat_o  (beat_o)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur                    <= '0;
      cur.mode_register_zero <= MR_RESET;
      cur.phase              <= PH_IDLE;
    end else if (clk_en_i) begin
      cur <= next_cur;
    end
  end

  assign dll_reset_o             = cur.dll_pulse;
  // no guarantees in this state, flagged only
  assign factory_test_o          =
    cur.mode_register_zero[TEST_BIT];
  assign column_access_latency_o = cur.cl;
  assign total_read_latency_o    = cur.rl;
  assign burst_order_type_o      = cur.mode_register_zero[ORDER_BIT];
  assign burst_size_field_o      = size_now;
  assign latency_illegal_o       = cur.lat_bad;
  assign size_illegal_o          = size_now == 2'h3;
  assign burst_busy_o            = cur.phase != PH_IDLE;
  assign cmd_refused_o           = cur.refused;
  assign internal_write_start_o  = cur.wr_start;

endmodule : dmz_mode_zero
`default_nettype wire

// ### dv/dmz_ctrl_model.sv
// memory controller model issuing commands on the device pins
`timescale 1ns/10ps
`default_nettype none
module dmz_ctrl_model (
  input  wire logic        core_clk_i,
  output logic             cmd_valid_o,
  output dmz_pkg::dmz_cmd_s cmd_o
);
  import dmz_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  task automatic send(input dmz_cmd_s c);
    @(posedge core_clk_i);
    #1 cmd_valid_o = 1'b1;
    cmd_o = c;
    @(posedge core_clk_i);
    // idle bus shows the inverse so a stale command never looks valid
    #1 cmd_valid_o = 1'b0;
    cmd_o = ~c;
  endtask : send
  // whole image every time, recovery field at its cap
  task automatic mode_set(input logic [4:0] code, input logic ord,
    input logic [1:0] size, input logic dll, input logic test_bit,
    input logic [3:0] sel);
    send({3'h0, sel, 4'h0, 1'b1, code[4], 3'h1, dll, test_bit, code[3:1],
      ord, code[0], size});
  endtask : mode_set
  task automatic access(input logic wr, input logic [2:0] col,
    input logic full);
    send({2'b10, !wr, 4'h0, 5'h00, full, 9'h000, col});
  endtask : access
endmodule : dmz_ctrl_model
`default_nettype wire

// ### dv/dmz_mode_zero_checker.sv
// concurrent checks on the mode register zero ports
`timescale 1ns/10ps
`default_nettype none
module dmz_mode_zero_checker (
  input wire logic               core_clk_i,
  input wire logic               rst_n_i,
  input wire logic               clk_en_i,
  input wire logic               cmd_valid_i,
  input wire dmz_pkg::dmz_cmd_s  cmd_i,
  input wire logic [4:0]         added_command_latency_i,
  input wire logic               dll_reset_o,
  input wire logic [5:0]         column_access_latency_o,
  input wire logic [6:0]         total_read_latency_o,
  input wire logic               burst_order_type_o,
  input wire logic [1:0]         burst_size_field_o,
  input wire logic               latency_illegal_o,
  input wire logic               burst_busy_o,
  input wire logic               cmd_refused_o,
  input wire logic               beat_valid_o,
  input wire logic               beat_ready_i,
  input wire dmz_pkg::dmz_beat_s beat_o
);
  import dmz_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire mset = cmd_valid_i && clk_en_i && cmd_i[24:22] == 3'h0 &&
    cmd_i[20:18] == 3'h0;
  wire [4:0] cod = {cmd_i.addr[12], cmd_i.addr[6:4], cmd_i.addr[2]};
  wire mset8 = mset && cmd_i.addr[8];
  wire rw = cmd_valid_i && clk_en_i && cmd_i.ras_n && !cmd_i.cas_n;
  wire [2:0] fld = {cmd_i.addr[3], cmd_i.addr[1:0]};
  property p_dll_set; mset8 |=> dll_reset_o; endproperty
  a_dll_set: assert property (p_dll_set) else $error("no dll pulse");
  property p_dll_src; dll_reset_o |-> $past(mset8) ||
    ($past(dll_reset_o) && !$past(clk_en_i)); endproperty
  a_dll_src: assert property (p_dll_src) else $error("stray dll");
  property p_fld; mset |=>
    {burst_order_type_o, burst_size_field_o} == $past(fld); endproperty
  a_fld: assert property (p_fld) else $error("fields");
  property p_keep; !$past(mset) |->
    $stable({burst_order_type_o, burst_size_field_o}); endproperty
  a_keep: assert property (p_keep) else $error("field moved");
  property p_bad; mset |=> latency_illegal_o ==
    ($past(cod) == 5'h12 || $past(cod) > 5'h17); endproperty
  a_bad: assert property (p_bad) else $error("illegal flag");
  property p_rl; $past(rst_n_i) && $past(clk_en_i) |-> total_read_latency_o
    == {2'h0, $past(added_command_latency_i)}
    + {1'h0, $past(column_access_latency_o)}; endproperty
  a_rl: assert property (p_rl) else $error("read latency");
  property p_busy; burst_busy_o && rw |-> ##[1:2] cmd_refused_o; endproperty
  a_busy: assert property (p_busy) else $error("not refused");
  property p_hold; beat_valid_o && !beat_ready_i |=>
    beat_valid_o && $stable(beat_o); endproperty
  a_hold: assert property (p_hold) else $error("beat lost");
endmodule : dmz_mode_zero_checker
bind dmz_mode_zero dmz_mode_zero_checker u_chk (.*);
`default_nettype wire

// ### dv/tb_top.sv
// bench for mode register zero, latency and burst ordering
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dmz_pkg::*;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
  logic beat_ready_i = 1'b1;
  logic [4:0] added_command_latency_i = 5'h00;
  logic cmd_valid_i, dll_reset_o, factory_test_o, burst_order_type_o, ord;
  logic latency_illegal_o, size_illegal_o, burst_busy_o, cmd_refused_o;
  logic internal_write_start_o, beat_valid_o;
  logic [1:0] burst_size_field_o, size;
  logic [5:0] column_access_latency_o;
  logic [6:0] total_read_latency_o;
  dmz_cmd_s cmd_i;
  dmz_beat_s beat_o;
  int fails, comparisons, cyc;
  int lat_tab [32] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17,
    19, 21, 25, 26, 0, 28, 29, 30, 31, 32, 0, 0, 0, 0, 0, 0, 0, 0};
  dmz_mode_zero u_dut (.*);
  dmz_ctrl_model u_ctrl (.core_clk_i, .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i));
  always #20 core_clk_i = ~core_clk_i;
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      end_of_test();
    end
  end
  // one burst; stall holds ready low to fill the buffer, then freezes once
  task automatic burst(input logic wr, input logic [2:0] s, input logic full,
    input logic stall, input int exp_lat, input logic go);
    // n is the edge at which the receiver takes what it sees now
    int n = 1, k = 0, fv = 0, ws = 0;
    logic ch, dr = 1'b0;
    logic [2:0] c, b;
    ch = size == 2'h2 || (size == 2'h1 && !full);
    if (go)
      u_ctrl.access(wr, s, full);
    while (k < 8 && n < 300) begin
      @(posedge core_clk_i);
      #1;
      n++;
      beat_ready_i = !stall || (fv > 0 && n > fv + 4);
      clk_en_i = !(stall && k == 3 && !dr);
      dr = dr || !clk_en_i;
      if (internal_write_start_o === 1'b1) ws = n;
      if (beat_valid_o === 1'b1 && fv == 0) fv = n;
      if (beat_valid_o === 1'b1 && beat_ready_i && clk_en_i) begin
        b = k[2:0];
        c = wr ? (ch ? {s[2], b[1:0]} : b) : ord ? s ^ b
          : {s[2] ^ b[2], s[1:0] + b[1:0]};
        c = (ch && b[2]) ? beat_o.col : c;
        chk(beat_o === {c, !(ch && b[2]), wr, b == 3'h7},
          "beat");
        k++;
      end
    end
    chk(k == 8, "beat count");
    if (go) chk(fv == (wr ? 2 : exp_lat), "first beat");
    if (wr && !stall)
      chk(ws == (size == 2'h2 ? 7 : 9), "write start");
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : burst
  task automatic t_latency();
    for (int i = 0; i < 32; i++) begin
      added_command_latency_i = 5'(31 - i);
      u_ctrl.mode_set(i[4:0], i[2], i[1:0], i == 5, i == 31, 4'h0);
      chk(dll_reset_o === (i == 5), "dll set");
      @(posedge core_clk_i);
      #1;
      chk(dll_reset_o === 1'b0, "dll clear");
      chk(column_access_latency_o === 6'(lat_tab[i]), "latency");
      chk(latency_illegal_o === (lat_tab[i] == 0), "illegal");
      chk(total_read_latency_o === 7'(31 - i + lat_tab[i]), "total");
      chk({factory_test_o, burst_order_type_o, burst_size_field_o,
        size_illegal_o} === {i == 31, i[2], i[1:0], i[1:0] == 2'h3},
        "fields");
    end
  endtask : t_latency
  task automatic t_read();
    added_command_latency_i = 5'h04;
    for (int m = 0; m < 6; m++) begin
      ord = m[0];
      size = m < 4 ? {m[1], 1'b0} : 2'h1;
      u_ctrl.mode_set(5'h01, ord, size, 1'b0, 1'b0, 4'h0);
      repeat (2) @(posedge core_clk_i);
      burst(1'b0, 3'(m * 3 + 1), m != 4, m == 5, 14, 1'b1);
    end
  endtask : t_read
  task automatic t_write();
    for (int m = 0; m < 4; m++) begin
      ord = !m[0];
      size = 2'(m == 1 ? 2 : m > 1);
      u_ctrl.mode_set(5'h01, ord, size, 1'b0, 1'b0, 4'h0);
      burst(1'b1, 3'(m * 3 + 5), m != 2, 1'b0, 0, 1'b1);
    end
  endtask : t_write
  task automatic t_busy();
    logic seen = 1'b0;
    added_command_latency_i = 5'h00;
    ord = 1'b0;
    size = 2'h0;
    beat_ready_i = 1'b0;
    u_ctrl.mode_set(5'h00, 1'b0, 2'h0, 1'b0, 1'b0, 4'h0);
    repeat (2) @(posedge core_clk_i);
    u_ctrl.access(1'b0, 3'h6, 1'b1);
    chk(burst_busy_o === 1'b1, "busy");
    u_ctrl.access(1'b1, 3'h1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      seen = seen || cmd_refused_o === 1'b1;
      @(posedge core_clk_i);
      #1;
    end
    chk(seen, "refused");
    // new order must not reach the burst already queued
    u_ctrl.mode_set(5'h00, 1'b1, 2'h0, 1'b0, 1'b0, 4'h0);
    burst(1'b0, 3'h6, 1'b1, 1'b0, 0, 1'b0);
    chk(burst_order_type_o === 1'b1, "order");
    u_ctrl.mode_set(5'h00, 1'b0, 2'h2, 1'b0, 1'b0, 4'h1);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({burst_order_type_o, burst_size_field_o} === 3'h4, "select");
  endtask : t_busy
  initial begin
    repeat (4) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    t_latency();
    t_read();
    t_write();
    t_busy();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
